// file: verilog/eie_pkg.sv
// Shared constants and types for the event entry unit.
// Assumes a 64-bit core that holds its requests until acknowledged.
package eie_pkg;

  // Register map, byte addresses on the APB side
  localparam logic [11:0] EIE_ADDR_STATUS = 12'h000;
  localparam logic [11:0] EIE_ADDR_SOFT   = 12'h004;
  localparam logic [11:0] EIE_ADDR_CTRL   = 12'h008;
  localparam logic [11:0] EIE_ADDR_LAST   = 12'h00c;

  // Status word layout
  localparam int EIE_SW_LSB    = 0;
  localparam int EIE_IP_BIT    = 2;
  localparam int EIE_CM_LSB    = 3;
  localparam int EIE_VMM_BIT   = 7;
  localparam int EIE_IPL_LSB   = 8;
  localparam int EIE_ALIGN_LSB = 56;
  localparam logic [63:0] EIE_STATUS_RESET = 64'h0000_0000_0000_1f00;

  // Priority levels
  localparam logic [4:0] EIE_IPL_MAX      = 5'h1f;
  localparam logic [4:0] EIE_IPL_SYS_CORR = 5'h14;
  localparam logic [4:0] EIE_IPL_HW_BASE  = 5'h10;

  // Frame geometry
  localparam logic [63:0] EIE_FRAME_BYTES = 64'h0000_0000_0000_0040;
  localparam logic [63:0] EIE_FRAME_MASK  = 64'hffff_ffff_ffff_ffc0;

  // Control register fields
  localparam int EIE_CTRL_PROVOKE = 0;
  localparam int EIE_CTRL_CLS_LSB = 1;

  localparam logic [1:0] EIE_MODE_KERNEL = 2'h0;

  typedef enum logic [1:0] {
    EIE_ST_IDLE   = 2'b00,
    EIE_ST_LOOKUP = 2'b01,
    EIE_ST_ENTER  = 2'b10,
    EIE_ST_RETURN = 2'b11
  } eie_state_t;

  typedef enum logic [1:0] {
    EIE_EV_NONE = 2'b00,
    EIE_EV_MCHK = 2'b01,
    EIE_EV_EXC  = 2'b10,
    EIE_EV_INT  = 2'b11
  } eie_event_t;

  typedef enum logic [2:0] {
    EIE_EXC_MM_FAULT   = 3'b000,
    EIE_EXC_ALIGN_TRAP = 3'b001,
    EIE_EXC_CHMODE     = 3'b010,
    EIE_EXC_ARITH      = 3'b011,
    EIE_EXC_OTHER      = 3'b100
  } eie_exc_t;

  typedef enum logic [1:0] {
    EIE_MC_PROC_CORR = 2'b00,
    EIE_MC_SYS_CORR  = 2'b01,
    EIE_MC_SYSTEM    = 2'b10,
    EIE_MC_PROCESSOR = 2'b11
  } eie_mc_t;

endpackage : eie_pkg

// file: verilog/eie_prio_pick.sv
// Interrupt priority picker: highest pending level above the current one.
// Assumes hardware lines already synchronised to pclk.
`timescale 1ns/100ps
`default_nettype none

module eie_prio_pick (
  input  wire logic [15:0] soft_pend,
  input  wire logic [31:0] hw_req,
  input  wire logic [4:0]  cur_ipl,
  output logic             pick_valid,
  output logic [4:0]       pick_level,
  output logic             pick_soft,
  output logic [4:0]       pick_line
);

  logic [31:0] lvl_req;

  genvar l;
  generate
    for (l = 0; l < 32; l++) begin : g_lvl
      if (l == 0) begin : g_zero
        assign lvl_req[l] = 1'b0;
      end else if (l < 16) begin : g_soft
        assign lvl_req[l] = soft_pend[l];
      end else begin : g_hw
        assign lvl_req[l] = hw_req[2*(l-16)] | hw_req[2*(l-16)+1];
      end
    end
  endgenerate

  // Ascending scan, so the last hit is the highest level
  always_comb begin
    pick_level = 5'h00;
    pick_valid = 1'b0;
    for (int i = 1; i < 32; i++) begin
      if (lvl_req[i] && (5'(i) > cur_ipl)) begin
        pick_level = 5'(i);
        pick_valid = 1'b1;
      end
    end
  end

  // Two lines share a hardware level; the even line wins
  always_comb begin
    pick_soft = ~pick_level[4];
    pick_line = 5'h00;
    if (pick_level[4]) begin
      pick_line = {pick_level[3:0], ~hw_req[{pick_level[3:0], 1'b0}]};
    end
  end

endmodule : eie_prio_pick

`default_nettype wire

// file: verilog/eie_entry_unit.sv
// Event entry unit: takes exceptions, interrupts and machine checks,
// builds the frame, loads argument registers and handles return.
// Assumes the core holds each request and its data until acknowledged.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Every event loads a new PC, may change mode/level, pushes old PC and status.
// - Taking an exception leaves the priority level unchanged.
// - Taking an interrupt raises the priority level above its old value.
// - Machine checks set level 20 if system correctable, otherwise 31.
// - Exceptions are taken at once whatever the priority level.
// - Interrupts wait until the level is strictly below the source level.
// - Deferred requests are taken only if still asserted when level drops.
// - Machine checks cannot be masked, may defer, and software may provoke one.
// - Unchecked exception conditions are dropped and leave no state.
// - The highest pending priority is always granted first.
// - Argument register 2 gets the dispatch vector after being saved.
// - Argument register 3 gets the dispatch parameter after being saved.
// - Register 4 gets fault address, write mask or nothing for the event.
// - Register 5 gets flags or summary; alignment direction 0 read, 1 write.
// - Saved PC is current or next instruction according to event type.
// - Machine checks save current PC, enter kernel, load logout offset.
// - Change-mode traps use the more privileged of current and requested mode.
// - Return restores saved PC and status and pops the frame.
// - Priority level is status word bits 12 to 8, values 0 to 31.
// - Levels 0 to 15 are software only, 16 to 31 hardware only.
// - Taking a software request clears its pending bit.
// - The frame is 64-byte aligned with args 2..7, PC and status.
module eie_entry_unit (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              exc_req,
  input  wire logic              exc_checks,
  input  wire logic [2:0]        exc_kind,
  input  wire logic [63:0]       exc_va,
  input  wire logic [63:0]       exc_mmf,
  input  wire logic [63:0]       exc_summary,
  input  wire logic [63:0]       exc_mask,
  input  wire logic              exc_write,
  input  wire logic [1:0]        chm_mode,
  input  wire logic              mc_req,
  input  wire logic              mc_defer,
  input  wire logic [1:0]        mc_class,
  input  wire logic [63:0]       logout_offset,
  input  wire logic [31:0]       hw_irq,
  input  wire logic [63:0]       cur_pc,
  input  wire logic [63:0]       next_pc,
  input  wire logic [5:0][63:0]  save_args,
  output logic [1:0]             stack_mode,
  input  wire logic [63:0]       stack_sp,
  output logic [7:0]             table_index,
  input  wire logic [63:0]       dispatch_vector,
  input  wire logic [63:0]       dispatch_parameter,
  input  wire logic              rei_req,
  input  wire logic [63:0]       rei_pc,
  input  wire logic [63:0]       rei_status,
  input  wire logic [63:0]       rei_frame_sp,
  output logic                   entry_valid,
  output logic                   rei_done,
  output logic [63:0]            new_pc,
  output logic [63:0]            new_sp,
  output logic [63:0]            status_word,
  output logic [7:0][63:0]       frame_words,
  output logic [63:0]            arg2,
  output logic [63:0]            arg3,
  output logic [63:0]            arg4,
  output logic [63:0]            arg5
);

  eie_pkg::eie_state_t state_reg;
  eie_pkg::eie_state_t state_next;
  eie_pkg::eie_event_t ev_reg;
  logic [2:0]  sub_reg;
  logic [4:0]  level_reg;
  logic        soft_reg;
  logic [1:0]  mode_reg;
  logic [15:0] soft_pend_reg;
  logic        provoke_reg;
  logic [1:0]  provoke_cls_reg;
  logic [31:0] irq_s1_reg;
  logic [31:0] irq_s2_reg;
  logic [31:0] irq_s3_reg;
  logic [31:0] irq_reg;
  logic [4:0]  priority_level;
  logic [1:0]  cm;
  logic        pick_valid;
  logic [4:0]  pick_level;
  logic        pick_soft;
  logic        mc_take;
  logic        exc_take;
  logic        apb_wr;
  logic        apb_acc;
  logic        soft_wr;
  logic        ctrl_wr;
  logic        status_wr;
  logic        taking;
  logic [63:0] saved_status;

  assign priority_level = status_word[eie_pkg::EIE_IPL_LSB +: 5];
  assign cm  = status_word[eie_pkg::EIE_CM_LSB +: 2];

  // Pin inputs: three stages, a bit moves once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_reg <= 32'h0000_0000;
      irq_s2_reg <= 32'h0000_0000;
      irq_s3_reg <= 32'h0000_0000;
      irq_reg    <= 32'h0000_0000;
    end else begin
      irq_s1_reg <= hw_irq;
      irq_s2_reg <= irq_s1_reg;
      irq_s3_reg <= irq_s2_reg;
      irq_reg    <= (irq_reg & (irq_s2_reg ^ irq_s3_reg)) | (irq_s2_reg & ~(irq_s2_reg ^ irq_s3_reg));
    end
  end

  // Hardware levels are sampled live, never latched
  eie_prio_pick u_pick (
    .soft_pend  (soft_pend_reg),
    .hw_req     (irq_reg),
    .cur_ipl    (priority_level),
    .pick_valid (pick_valid),
    .pick_level (pick_level),
    .pick_soft  (pick_soft),
    .pick_line  ()
  );

  // APB decode, zero wait states
  assign apb_acc   = psel & penable;
  assign apb_wr    = apb_acc & pwrite;
  assign status_wr = apb_wr & (paddr == eie_pkg::EIE_ADDR_STATUS);
  assign soft_wr   = apb_wr & (paddr == eie_pkg::EIE_ADDR_SOFT);
  assign ctrl_wr   = apb_wr & (paddr == eie_pkg::EIE_ADDR_CTRL);
  assign pready    = 1'b1;
  assign pslverr   = apb_acc & (paddr != eie_pkg::EIE_ADDR_STATUS) & (paddr != eie_pkg::EIE_ADDR_SOFT)
                   & (paddr != eie_pkg::EIE_ADDR_CTRL) & (paddr != eie_pkg::EIE_ADDR_LAST);

  always_comb begin
    case (paddr)
      eie_pkg::EIE_ADDR_STATUS: prdata = status_word[31:0];
      eie_pkg::EIE_ADDR_SOFT:   prdata = {16'h0000, soft_pend_reg};
      eie_pkg::EIE_ADDR_CTRL:   prdata = {29'h0000_0000, provoke_cls_reg, provoke_reg};
      eie_pkg::EIE_ADDR_LAST:   prdata = {18'h0_0000, 1'b0, level_reg, mode_reg, ev_reg, sub_reg, soft_reg};
      default:                  prdata = 32'h0000_0000;
    endcase
  end

  // Selection: machine check, then exception, then interrupt, then return
  assign mc_take  = (mc_req & ~mc_defer) | provoke_reg;
  assign exc_take = exc_req & exc_checks;
  assign taking   = (state_reg == eie_pkg::EIE_ST_LOOKUP);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      eie_pkg::EIE_ST_IDLE: begin
        if (mc_take || exc_take || pick_valid) begin
          state_next = eie_pkg::EIE_ST_LOOKUP;
        end else if (rei_req) begin
          state_next = eie_pkg::EIE_ST_RETURN;
        end
      end
      eie_pkg::EIE_ST_LOOKUP: state_next = eie_pkg::EIE_ST_ENTER;
      eie_pkg::EIE_ST_ENTER:  state_next = eie_pkg::EIE_ST_IDLE;
      eie_pkg::EIE_ST_RETURN: state_next = eie_pkg::EIE_ST_IDLE;
      default:                state_next = eie_pkg::EIE_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= eie_pkg::EIE_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Event capture while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_reg    <= eie_pkg::EIE_EV_NONE;
      sub_reg   <= 3'h0;
      level_reg <= 5'h00;
      soft_reg  <= 1'b0;
      mode_reg  <= eie_pkg::EIE_MODE_KERNEL;
    end else if (state_reg == eie_pkg::EIE_ST_IDLE && state_next == eie_pkg::EIE_ST_LOOKUP) begin
      soft_reg <= 1'b0;
      mode_reg <= eie_pkg::EIE_MODE_KERNEL;
      if (mc_take) begin
        ev_reg  <= eie_pkg::EIE_EV_MCHK;
        sub_reg <= {1'b0, provoke_reg ? provoke_cls_reg : mc_class};
      end else if (exc_take) begin
        ev_reg  <= eie_pkg::EIE_EV_EXC;
        sub_reg <= exc_kind;
        if (exc_kind == eie_pkg::EIE_EXC_CHMODE) begin
          mode_reg <= (chm_mode < cm) ? chm_mode : cm;
        end
      end else begin
        ev_reg    <= eie_pkg::EIE_EV_INT;
        sub_reg   <= 3'h0;
        level_reg <= pick_level;
        soft_reg  <= pick_soft;
      end
    end
  end

  assign table_index = {ev_reg, (ev_reg == eie_pkg::EIE_EV_INT) ? {1'b0, level_reg} : {3'h0, sub_reg}};
  assign stack_mode  = mode_reg;
  assign entry_valid = (state_reg == eie_pkg::EIE_ST_ENTER);
  assign rei_done    = (state_reg == eie_pkg::EIE_ST_RETURN);

  // Software pending bits; a new request beats the clear on take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_pend_reg <= 16'h0000;
    end else begin
      soft_pend_reg <= (soft_pend_reg
                        & ~((taking && ev_reg == eie_pkg::EIE_EV_INT && soft_reg)
                            ? (16'h0001 << level_reg[3:0]) : 16'h0000))
                       | (soft_wr ? (pwdata[15:0] & 16'hfffe) : 16'h0000);
    end
  end

  // Software-provoked machine check, held until taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      provoke_reg     <= 1'b0;
      provoke_cls_reg <= 2'h0;
    end else begin
      if (ctrl_wr && pwdata[eie_pkg::EIE_CTRL_PROVOKE]) begin
        provoke_reg     <= 1'b1;
        provoke_cls_reg <= pwdata[eie_pkg::EIE_CTRL_CLS_LSB +: 2];
      end else if (taking && ev_reg == eie_pkg::EIE_EV_MCHK) begin
        provoke_reg <= 1'b0;
      end
    end
  end

  // Status word: entry and return take priority over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word <= eie_pkg::EIE_STATUS_RESET;
    end else if (taking) begin
      status_word[eie_pkg::EIE_SW_LSB +: 2] <= 2'h0;
      status_word[eie_pkg::EIE_IP_BIT]      <= (ev_reg == eie_pkg::EIE_EV_INT);
      status_word[eie_pkg::EIE_CM_LSB +: 2] <= mode_reg;
      case (ev_reg)
        eie_pkg::EIE_EV_INT: status_word[eie_pkg::EIE_IPL_LSB +: 5] <= level_reg;
        eie_pkg::EIE_EV_MCHK: status_word[eie_pkg::EIE_IPL_LSB +: 5] <=
          (sub_reg[1:0] == eie_pkg::EIE_MC_SYS_CORR) ? eie_pkg::EIE_IPL_SYS_CORR : eie_pkg::EIE_IPL_MAX;
        default: status_word[eie_pkg::EIE_IPL_LSB +: 5] <= priority_level;
      endcase
    end else if (state_reg == eie_pkg::EIE_ST_IDLE && state_next == eie_pkg::EIE_ST_RETURN) begin
      status_word <= {8'h00, 43'h0, rei_status[12:7], 2'h0, rei_status[4:0]};
    end else if (status_wr) begin
      status_word[eie_pkg::EIE_IPL_LSB +: 5] <= pwdata[eie_pkg::EIE_IPL_LSB +: 5];
      status_word[eie_pkg::EIE_SW_LSB +: 2]  <= pwdata[eie_pkg::EIE_SW_LSB +: 2];
    end
  end

  always_comb begin
    saved_status = status_word;
    saved_status[eie_pkg::EIE_ALIGN_LSB +: 6] = stack_sp[5:0];
  end

  // Frame, new PC, stack pointer and argument loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_pc      <= 64'h0;
      new_sp      <= 64'h0;
      frame_words <= '0;
      arg2        <= 64'h0;
      arg3        <= 64'h0;
      arg4        <= 64'h0;
      arg5        <= 64'h0;
    end else if (taking) begin
      new_pc                <= {dispatch_vector[63:2], 2'b00};
      new_sp                <= (stack_sp & eie_pkg::EIE_FRAME_MASK) - eie_pkg::EIE_FRAME_BYTES;
      frame_words[5:0]      <= save_args;
      frame_words[7]        <= saved_status;
      frame_words[6]        <= cur_pc;
      if (ev_reg == eie_pkg::EIE_EV_EXC && sub_reg != eie_pkg::EIE_EXC_MM_FAULT
          && sub_reg != eie_pkg::EIE_EXC_OTHER) begin
        frame_words[6] <= next_pc;
      end
      arg2 <= dispatch_vector;
      arg3 <= dispatch_parameter;
      arg4 <= 64'h0;
      arg5 <= 64'h0;
      if (ev_reg == eie_pkg::EIE_EV_MCHK) begin
        arg4 <= logout_offset;
      end else if (ev_reg == eie_pkg::EIE_EV_EXC) begin
        case (sub_reg)
          eie_pkg::EIE_EXC_MM_FAULT: begin
            arg4 <= exc_va;
            arg5 <= exc_mmf;
          end
          eie_pkg::EIE_EXC_ALIGN_TRAP: begin
            arg4 <= exc_va;
            arg5 <= {63'h0, exc_write};
          end
          eie_pkg::EIE_EXC_ARITH: begin
            arg4 <= exc_mask;
            arg5 <= exc_summary;
          end
          default: arg4 <= 64'h0;
        endcase
      end
    end else if (state_reg == eie_pkg::EIE_ST_IDLE && state_next == eie_pkg::EIE_ST_RETURN) begin
      new_pc <= {rei_pc[63:2], 2'b00};
      new_sp <= rei_frame_sp + eie_pkg::EIE_FRAME_BYTES + {58'h0, rei_status[61:56]};
    end
  end

  // Checks
  exc_ipl_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking && ev_reg == eie_pkg::EIE_EV_EXC |=> priority_level == $past(priority_level))
    else $error("exception changed priority level");
  int_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking && ev_reg == eie_pkg::EIE_EV_INT |=> priority_level > $past(priority_level))
    else $error("interrupt did not raise level");
  mc_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking && ev_reg == eie_pkg::EIE_EV_MCHK |=> priority_level == (($past(sub_reg[1:0]) == eie_pkg::EIE_MC_SYS_CORR) ? 5'h14 : 5'h1f))
    else $error("machine check level wrong");
  exc_now_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == eie_pkg::EIE_ST_IDLE && exc_req && exc_checks |=> taking ##1 entry_valid)
    else $error("exception not taken at once");
  int_defer_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking && ev_reg == eie_pkg::EIE_EV_INT |-> level_reg > priority_level)
    else $error("interrupt taken at or below level");
  unchecked_exc_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == eie_pkg::EIE_ST_IDLE && exc_req && !exc_checks && !mc_take && !pick_valid && !rei_req
    |=> state_reg == eie_pkg::EIE_ST_IDLE)
    else $error("unchecked exception was taken");
  soft_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking && ev_reg == eie_pkg::EIE_EV_INT && soft_reg && !soft_wr |=> !soft_pend_reg[$past(level_reg[3:0])])
    else $error("soft pending bit not cleared");
  frame_align_a: assert property (@(posedge pclk) disable iff (!presetn)
    entry_valid |-> new_sp[5:0] == 6'h00 && frame_words[5] == $past(save_args[5]))
    else $error("frame misaligned or args lost");
  arg_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking |=> arg2 == $past(dispatch_vector) && arg3 == $past(dispatch_parameter))
    else $error("dispatch words not loaded");
  mc_kernel_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking && ev_reg == eie_pkg::EIE_EV_MCHK |=> cm == 2'h0 && arg4 == $past(logout_offset)
      && frame_words[6] == $past(cur_pc))
    else $error("machine check entry wrong");
  chm_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    taking && ev_reg == eie_pkg::EIE_EV_EXC && sub_reg == eie_pkg::EIE_EXC_CHMODE |-> mode_reg <= cm)
    else $error("change mode went less privileged");

  cov_int_c:  cover property (@(posedge pclk) disable iff (!presetn) taking && ev_reg == eie_pkg::EIE_EV_INT);
  cov_mc_c:   cover property (@(posedge pclk) disable iff (!presetn) taking && ev_reg == eie_pkg::EIE_EV_MCHK);
  cov_exc_c:  cover property (@(posedge pclk) disable iff (!presetn) taking && ev_reg == eie_pkg::EIE_EV_EXC);
  cov_rei_c:  cover property (@(posedge pclk) disable iff (!presetn) rei_done);

endmodule : eie_entry_unit

`default_nettype wire

// file: testbench/eie_core_model.sv
// Partner model: dispatch table and stack pointer lookup for the entry unit.
// Assumes both answers are read during the lookup cycle.
`timescale 1ns/100ps
`default_nettype none

module eie_core_model (
  input  wire logic [7:0]  table_index,
  input  wire logic [1:0]  stack_mode,
  output logic      [63:0] dispatch_vector,
  output logic      [63:0] dispatch_parameter,
  output logic      [63:0] stack_sp
);
  // Odd low bits so that cleared pc bits show
  assign dispatch_vector    = {40'h0, 8'hd5, table_index, 8'h07};
  assign dispatch_parameter = ~dispatch_vector;
  // Unaligned pointer exercises the frame alignment
  assign stack_sp           = {54'h8, stack_mode, 8'h2c};
endmodule : eie_core_model

`default_nettype wire

// file: testbench/eie_entry_unit_tb_top.sv
// Testbench for the event entry unit: APB tasks plus event scenarios.
// Assumes the core model answers the dispatch and stack lookups.
`timescale 1ns/100ps
`default_nettype none

module eie_entry_unit_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exc_req, exc_checks, exc_write;
  logic mc_req, mc_defer, rei_req, entry_valid, rei_done, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hw_irq, rd;
  logic [2:0] exc_kind;
  logic [1:0] chm_mode, mc_class, stack_mode;
  logic [7:0] table_index;
  logic [63:0] exc_va, exc_mmf, exc_summary, exc_mask, logout_offset, cur_pc, next_pc, stack_sp;
  logic [63:0] dispatch_vector, dispatch_parameter, rei_pc, rei_status, rei_frame_sp;
  logic [63:0] new_pc, new_sp, status_word, arg2, arg3, arg4, arg5;
  logic [5:0][63:0] save_args;
  logic [7:0][63:0] frame_words;
  int n_fail, comparisons, hits;

  eie_entry_unit uut (.*);
  eie_core_model model (.*);

  function automatic logic [63:0] vec(input logic [7:0] i);
    return {40'h0, 8'hd5, i, 8'h07};
  endfunction : vec

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ev(input logic return_from_event);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while ((return_from_event ? rei_done : entry_valid) !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      conclude();
    end
    @(posedge pclk);
    exc_req <= 1'b0;
    mc_req <= 1'b0;
    rei_req <= 1'b0;
    hw_irq <= '0;
  endtask : wait_ev

  task automatic quiet;
    hits = 0;
    repeat (10) begin
      @(posedge pclk);
      #1;
      if (entry_valid === 1'b1) hits++;
    end
    // Back on the edge so callers drive at it
    @(posedge pclk);
    chk(64'(hits), 64'h0);
  endtask : quiet

  task automatic ent(input logic [7:0] i, input logic [4:0] lvl);
    chk(arg2, vec(i));
    chk(arg3, ~vec(i));
    chk(new_pc, vec(i) & ~64'h3);
    chk(64'(status_word[12:8]), 64'(lvl));
    chk(frame_words[0], 64'h0000_0000_0000_face);
  endtask : ent

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    {psel, penable, pwrite, exc_req, exc_write, mc_req, mc_defer, rei_req} = '0;
    {paddr, pwdata, hw_irq, exc_kind, chm_mode, mc_class} = '0;
    {exc_va, exc_mmf, exc_summary, exc_mask, rei_pc, rei_status, rei_frame_sp} = '0;
    exc_checks = 1'b1;
    logout_offset = 64'h0000_0000_0000_0a80;
    cur_pc = 64'h0000_0000_0001_0000;
    next_pc = 64'h0000_0000_0001_0004;
    save_args = '0;
    save_args[0] = 64'h0000_0000_0000_face;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, eie_pkg::EIE_ADDR_STATUS, 32'h0);
    chk({32'h0, rd}, 64'h1f00);
    apb(1'b0, 12'h040, 32'h0);
    chk({63'h0, err}, 64'h1);
    $display("test reset done");
    @(posedge pclk);
    exc_req <= 1'b1;
    exc_va <= 64'h1234_5678_9abc_def0;
    exc_mmf <= 64'h0000_0000_0000_0005;
    wait_ev(1'b0);
    ent(8'h80, 5'h1f);
    chk(frame_words[6], cur_pc);
    chk(arg4, 64'h1234_5678_9abc_def0);
    chk(arg5, 64'h5);
    chk(new_sp, 64'h0000_0000_0000_1fc0);
    @(posedge pclk);
    exc_req <= 1'b1;
    exc_kind <= eie_pkg::EIE_EXC_ALIGN_TRAP;
    exc_write <= 1'b1;
    wait_ev(1'b0);
    ent(8'h81, 5'h1f);
    chk(frame_words[6], next_pc);
    chk(arg5, 64'h1);
    @(posedge pclk);
    exc_req <= 1'b1;
    exc_checks <= 1'b0;
    quiet();
    exc_req <= 1'b0;
    exc_checks <= 1'b1;
    $display("test exceptions done");
    @(posedge pclk);
    mc_req <= 1'b1;
    mc_defer <= 1'b1;
    mc_class <= eie_pkg::EIE_MC_SYS_CORR;
    quiet();
    mc_defer <= 1'b0;
    wait_ev(1'b0);
    ent(8'h41, 5'h14);
    chk(frame_words[6], cur_pc);
    chk(arg4, 64'h0a80);
    chk(64'(status_word[4:3]), 64'h0);
    apb(1'b1, eie_pkg::EIE_ADDR_CTRL, 32'h1);
    wait_ev(1'b0);
    ent(8'h40, 5'h1f);
    $display("test machine checks done");
    apb(1'b1, eie_pkg::EIE_ADDR_STATUS, 32'h1200);
    hw_irq <= 32'h14;
    quiet();
    apb(1'b1, eie_pkg::EIE_ADDR_STATUS, 32'h1000);
    wait_ev(1'b0);
    ent(8'hd2, 5'h12);
    apb(1'b1, eie_pkg::EIE_ADDR_SOFT, 32'h20);
    apb(1'b1, eie_pkg::EIE_ADDR_STATUS, 32'h0400);
    wait_ev(1'b0);
    ent(8'hc5, 5'h05);
    apb(1'b0, eie_pkg::EIE_ADDR_SOFT, 32'h0);
    chk({32'h0, rd}, 64'h0);
    $display("test interrupts done");
    @(posedge pclk);
    rei_req <= 1'b1;
    rei_pc <= 64'h0000_0000_4000_0010;
    rei_status <= 64'h0200_0000_0000_0318;
    rei_frame_sp <= 64'h0000_0000_0000_1000;
    wait_ev(1'b1);
    chk(new_pc, 64'h4000_0010);
    chk(new_sp, 64'h1042);
    chk(64'(status_word[12:0]), 64'h318);
    $display("test return done");
    @(posedge pclk);
    exc_req <= 1'b1;
    exc_kind <= eie_pkg::EIE_EXC_CHMODE;
    chm_mode <= 2'h1;
    wait_ev(1'b0);
    ent(8'h82, 5'h03);
    chk(64'(status_word[4:3]), 64'h1);
    chk(frame_words[6], next_pc);
    @(posedge pclk);
    exc_req <= 1'b1;
    exc_kind <= eie_pkg::EIE_EXC_ARITH;
    exc_mask <= 64'h0000_0000_0000_00f0;
    exc_summary <= 64'h0000_0000_0000_0021;
    wait_ev(1'b0);
    ent(8'h83, 5'h03);
    chk(arg4, 64'hf0);
    chk(arg5, 64'h21);
    $display("test trap kinds done");
    conclude();
  end
endmodule : eie_entry_unit_tb_top

`default_nettype wire
